/* File: core/serial_tx_top.v */
// Asynchronous serial transmitter with clock select, format select and AXI4-Lite registers
// Behaviour
// - Select 00: internal generator, clock pin unused
// - Select 01: internal, clock pin outputs 16x
// - Twelve formats: length, parity, stop count
// - Frame starts with one low start bit
// - Seven or eight data bits, LSB first
// - Optional single even or odd parity bit
// - One or two high stop bits close frame
// - Clock output runs once control register written
// - Clearing transmit enable reinitialises shift register
// - Disable keeps status and FIFO contents
// - Disable mid-frame floats transmit line at once
// - Enabled transmitter idles at mark
// - FIFO data sent back to back until empty
// - Below trigger sets empty flag and interrupt
// - At stop time, next byte loaded if present
// - Empty at stop time sets end flag, mark
// - Trigger codes give levels 8, 4, 2, 1
// - FIFO count register upper byte shows fill
`timescale 1ns/100ps
`include "serial_tx_regs.vh"
`default_nettype none
module serial_tx_top #(
    parameter DATA_W = 8,
    parameter FIFO_LOG2 = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sck_in,
    output reg sck_out,
    output reg sck_oe,
    output reg txd_out,
    output reg txd_oe,
    output reg tx_irq
);
    localparam ST_IDLE = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_DATA = 3'd2;
    localparam ST_PARITY = 3'd3;
    localparam ST_STOP = 3'd4;

    reg [7:0] format_reg;
    reg [7:0] control_reg;
    reg [7:0] bit_rate_reg;
    reg [7:0] fifo_control_reg;
    reg tx_end_flag;
    reg tx_fifo_empty_flag;

    reg [`ADDR_W-1:0] aw_addr_reg;
    reg aw_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_held_reg;

    reg [2:0] state_reg;
    reg [3:0] sub_reg;
    reg [3:0] bit_cnt_reg;
    reg [DATA_W-1:0] shift_reg;
    reg parity_reg;
    reg second_stop_reg;
    reg [DATA_W-1:0] next_char_reg;
    reg next_valid_reg;

    reg sck_meta_reg;
    reg sck_sync_reg;
    reg sck_prev_reg;

    wire clock_select_lo = control_reg[`CTL_CLK_LO];
    wire clock_select_hi = control_reg[`CTL_CLK_HI];
    wire tx_enable = control_reg[`CTL_TX_EN];
    wire tx_irq_enable = control_reg[`CTL_TX_IRQ_EN];
    wire char_length_sel = format_reg[`FMT_CHAR_LEN];
    wire parity_enable = format_reg[`FMT_PARITY_EN];
    wire parity_odd = format_reg[`FMT_PARITY_ODD];
    wire two_stop = format_reg[`FMT_STOP];
    wire tx_fifo_reset = fifo_control_reg[`FCR_TX_FIFO_RST];

    // Trigger field decode, used for the flag compare and nowhere else in hardware
    function [4:0] trig_level;
        input [1:0] code;
        begin
            case (code)
                `TRIG_CODE_8: trig_level = `TRIG_LEVEL_8;
                `TRIG_CODE_4: trig_level = `TRIG_LEVEL_4;
                `TRIG_CODE_2: trig_level = `TRIG_LEVEL_2;
                default: trig_level = `TRIG_LEVEL_1;
            endcase
        end
    endfunction

    // Parity over the active data bits; the unused top bit is masked off in 7-bit mode
    function parity_of;
        input [DATA_W-1:0] data;
        input short;
        input odd;
        begin
            parity_of = ^(short ? {1'b0, data[DATA_W-2:0]} : data) ^ odd;
        end
    endfunction

    // Write decode
    wire wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire wr_byte0 = wr_fire && w_strb_reg[0];
    wire wr_format = wr_byte0 && (aw_addr_reg == `OFS_FORMAT);
    wire wr_control = wr_byte0 && (aw_addr_reg == `OFS_CONTROL);
    wire wr_rate = wr_byte0 && (aw_addr_reg == `OFS_BIT_RATE);
    wire wr_status = wr_byte0 && (aw_addr_reg == `OFS_STATUS);
    wire wr_fcr = wr_byte0 && (aw_addr_reg == `OFS_FIFO_CONTROL);
    wire wr_fifo = wr_byte0 && (aw_addr_reg == `OFS_TX_FIFO);
    wire wr_mapped = (aw_addr_reg == `OFS_FORMAT) || (aw_addr_reg == `OFS_CONTROL) ||
                     (aw_addr_reg == `OFS_BIT_RATE) || (aw_addr_reg == `OFS_STATUS) ||
                     (aw_addr_reg == `OFS_FIFO_CONTROL) || (aw_addr_reg == `OFS_TX_FIFO);

    // FIFO
    wire [DATA_W-1:0] fifo_head;
    wire [FIFO_LOG2:0] fifo_count;
    wire fifo_has = (fifo_count != {(FIFO_LOG2+1){1'b0}});
    reg fifo_pop;

    tx_char_fifo #(
        .WIDTH(DATA_W),
        .DEPTH_LOG2(FIFO_LOG2)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .flush(tx_fifo_reset),
        .push(wr_fifo),
        .push_data(w_data_reg[DATA_W-1:0]),
        .pop(fifo_pop),
        .head(fifo_head),
        .count_reg(fifo_count)
    );

    // Internal bit clock
    wire int_clk16;
    wire int_tick;

    tx_bit_rate_gen #(
        .DIV_W(8)
    ) u_brg (
        .aclk(aclk),
        .aresetn(aresetn),
        .divisor(bit_rate_reg),
        .clk16_reg(int_clk16),
        .tick_reg(int_tick)
    );

    // External 16x clock, synchronised; the second and third stages feed the edge detect
    always @(posedge aclk) begin
        if (!aresetn) begin
            sck_meta_reg <= 1'b0;
            sck_sync_reg <= 1'b0;
            sck_prev_reg <= 1'b0;
        end else begin
            sck_meta_reg <= sck_in;
            sck_sync_reg <= sck_meta_reg;
            sck_prev_reg <= sck_sync_reg;
        end
    end

    wire ext_tick = sck_sync_reg && !sck_prev_reg;
    wire tick16 = clock_select_hi ? ext_tick : int_tick;
    wire bit_tick = tick16 && (sub_reg == `LAST_TICK);
    wire [3:0] last_bit = char_length_sel ? (`BITS_SHORT - 4'h1) : (`BITS_LONG - 4'h1);

    // Clock pin drives only in select 01, from the moment control is written
    always @(posedge aclk) begin
        if (!aresetn) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
        end else begin
            sck_oe <= !clock_select_hi && clock_select_lo;
            sck_out <= int_clk16 && !clock_select_hi && clock_select_lo;
        end
    end

    // Transmit sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            sub_reg <= 4'h0;
            bit_cnt_reg <= 4'h0;
            shift_reg <= {DATA_W{1'b0}};
            parity_reg <= 1'b0;
            second_stop_reg <= 1'b0;
            next_char_reg <= {DATA_W{1'b0}};
            next_valid_reg <= 1'b0;
            fifo_pop <= 1'b0;
        end else if (!tx_enable) begin
            state_reg <= ST_IDLE;
            sub_reg <= 4'h0;
            bit_cnt_reg <= 4'h0;
            shift_reg <= {DATA_W{1'b0}};
            second_stop_reg <= 1'b0;
            next_valid_reg <= 1'b0;
            fifo_pop <= 1'b0;
        end else begin
            fifo_pop <= 1'b0;
            if (tick16)
                sub_reg <= sub_reg + 1'b1;
            case (state_reg)
                ST_IDLE: begin
                    if (fifo_has && !fifo_pop) begin
                        shift_reg <= fifo_head;
                        parity_reg <= parity_of(fifo_head, char_length_sel, parity_odd);
                        fifo_pop <= 1'b1;
                        sub_reg <= 4'h0;
                        state_reg <= ST_START;
                    end
                end
                ST_START: begin
                    if (bit_tick) begin
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (bit_tick) begin
                        shift_reg <= shift_reg >> 1;
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        if (bit_cnt_reg == last_bit) begin
                            if (parity_enable) begin
                                state_reg <= ST_PARITY;
                            end else begin
                                state_reg <= ST_STOP;
                                second_stop_reg <= 1'b0;
                                if (fifo_has) begin
                                    next_char_reg <= fifo_head;
                                    next_valid_reg <= 1'b1;
                                    fifo_pop <= 1'b1;
                                end
                            end
                        end
                    end
                end
                ST_PARITY: begin
                    if (bit_tick) begin
                        state_reg <= ST_STOP;
                        second_stop_reg <= 1'b0;
                        if (fifo_has) begin
                            next_char_reg <= fifo_head;
                            next_valid_reg <= 1'b1;
                            fifo_pop <= 1'b1;
                        end
                    end
                end
                ST_STOP: begin
                    if (bit_tick) begin
                        if (two_stop && !second_stop_reg) begin
                            second_stop_reg <= 1'b1;
                        end else if (next_valid_reg) begin
                            shift_reg <= next_char_reg;
                            parity_reg <= parity_of(next_char_reg, char_length_sel, parity_odd);
                            next_valid_reg <= 1'b0;
                            state_reg <= ST_START;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // End of data seen at stop time: fires as the stop bit begins with nothing queued
    wire stop_entry = tx_enable && bit_tick &&
                      ((state_reg == ST_PARITY) ||
                       (state_reg == ST_DATA && bit_cnt_reg == last_bit && !parity_enable));
    wire set_tx_end = stop_entry && !fifo_has;
    wire set_empty = (fifo_count < trig_level(fifo_control_reg[`FCR_TRIG_HI:`FCR_TRIG_LO]));

    // Line and output enable; one cycle behind the sequencer state
    always @(posedge aclk) begin
        if (!aresetn) begin
            txd_out <= 1'b1;
            txd_oe <= 1'b0;
            tx_irq <= 1'b0;
        end else begin
            txd_oe <= tx_enable;
            case (state_reg)
                ST_START: txd_out <= 1'b0;
                ST_DATA: txd_out <= shift_reg[0];
                ST_PARITY: txd_out <= parity_reg;
                default: txd_out <= 1'b1;
            endcase
            tx_irq <= tx_fifo_empty_flag && tx_irq_enable;
        end
    end

    // Configuration registers; disabling touches none of the status or FIFO state
    always @(posedge aclk) begin
        if (!aresetn) begin
            format_reg <= `FORMAT_RST;
            control_reg <= `CONTROL_RST;
            bit_rate_reg <= `BIT_RATE_RST;
            fifo_control_reg <= `FCR_RST;
        end else begin
            if (wr_format)
                format_reg <= w_data_reg[7:0];
            if (wr_control)
                control_reg <= w_data_reg[7:0];
            if (wr_rate)
                bit_rate_reg <= w_data_reg[7:0];
            if (wr_fcr)
                fifo_control_reg <= w_data_reg[7:0];
        end
    end

    // Status flags: writing 0 clears, a hardware set in the same cycle wins
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_end_flag <= 1'b1;
            tx_fifo_empty_flag <= 1'b1;
        end else begin
            if (set_tx_end)
                tx_end_flag <= 1'b1;
            else if (wr_status && !w_data_reg[`STS_TX_END])
                tx_end_flag <= 1'b0;
            if (set_empty)
                tx_fifo_empty_flag <= 1'b1;
            else if (wr_status && !w_data_reg[`STS_TX_FIFO_EMPTY])
                tx_fifo_empty_flag <= 1'b0;
        end
    end

    // Write channel: address and data latched independently, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= {`ADDR_W{1'b0}};
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                s_axi_rdata <= 32'h00000000;
                case (s_axi_araddr)
                    `OFS_FORMAT: s_axi_rdata[7:0] <= format_reg;
                    `OFS_CONTROL: s_axi_rdata[7:0] <= control_reg;
                    `OFS_BIT_RATE: s_axi_rdata[7:0] <= bit_rate_reg;
                    `OFS_STATUS: begin
                        s_axi_rdata[`STS_TX_END] <= tx_end_flag;
                        s_axi_rdata[`STS_TX_FIFO_EMPTY] <= tx_fifo_empty_flag;
                    end
                    `OFS_FIFO_CONTROL: s_axi_rdata[7:0] <= fifo_control_reg;
                    `OFS_FIFO_COUNT: s_axi_rdata[`CNT_TX_LO+FIFO_LOG2:`CNT_TX_LO] <= fifo_count;
                    `OFS_TX_FIFO: s_axi_rdata <= 32'h00000000;
                    default: s_axi_rresp <= `RESP_SLVERR;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // serial_tx_top
`default_nettype wire

/* File: core/tx_bit_rate_gen.v */
// Internal 16x bit clock generator with square-wave clock output
`timescale 1ns/100ps
`default_nettype none
module tx_bit_rate_gen #(
    parameter DIV_W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [DIV_W-1:0] divisor,
    output reg clk16_reg,
    output reg tick_reg
);
    reg [DIV_W-1:0] cnt_reg;

    // One 16x period spans two half periods of divisor+1 cycles each
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= {DIV_W{1'b0}};
            clk16_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (cnt_reg >= divisor) begin
                cnt_reg <= {DIV_W{1'b0}};
                clk16_reg <= ~clk16_reg;
                tick_reg <= ~clk16_reg;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
endmodule // tx_bit_rate_gen
`default_nettype wire

/* File: core/tx_char_fifo.v */
// Transmit character FIFO held in flip-flops
`timescale 1ns/100ps
`default_nettype none
module tx_char_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH_LOG2 = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire flush,
    input wire push,
    input wire [WIDTH-1:0] push_data,
    input wire pop,
    output wire [WIDTH-1:0] head,
    output reg [DEPTH_LOG2:0] count_reg
);
    localparam DEPTH = 1 << DEPTH_LOG2;
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [DEPTH_LOG2-1:0] wr_reg;
    reg [DEPTH_LOG2-1:0] rd_reg;
    wire full = (count_reg == DEPTH[DEPTH_LOG2:0]);
    wire empty = (count_reg == {(DEPTH_LOG2+1){1'b0}});
    wire do_push = push && !full;
    wire do_pop = pop && !empty;

    assign head = mem_reg[rd_reg];

    always @(posedge aclk) begin
        if (do_push)
            mem_reg[wr_reg] <= push_data;
    end

    // Writes into a full FIFO are dropped; software is meant to respect the count
    always @(posedge aclk) begin
        if (!aresetn || flush) begin
            wr_reg <= {DEPTH_LOG2{1'b0}};
            rd_reg <= {DEPTH_LOG2{1'b0}};
            count_reg <= {(DEPTH_LOG2+1){1'b0}};
        end else begin
            if (do_push)
                wr_reg <= wr_reg + 1'b1;
            if (do_pop)
                rd_reg <= rd_reg + 1'b1;
            if (do_push && !do_pop)
                count_reg <= count_reg + 1'b1;
            else if (do_pop && !do_push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule // tx_char_fifo
`default_nettype wire

/* File: include/serial_tx_regs.vh */
// Register map, field positions and constants for the serial transmit block
`ifndef SERIAL_TX_REGS_VH
`define SERIAL_TX_REGS_VH

`define ADDR_W 8
`define OFS_FORMAT 8'h00
`define OFS_CONTROL 8'h04
`define OFS_BIT_RATE 8'h08
`define OFS_STATUS 8'h0C
`define OFS_FIFO_CONTROL 8'h10
`define OFS_FIFO_COUNT 8'h14
`define OFS_TX_FIFO 8'h18

`define FMT_STOP 3
`define FMT_PARITY_ODD 4
`define FMT_PARITY_EN 5
`define FMT_CHAR_LEN 6

`define CTL_CLK_LO 0
`define CTL_CLK_HI 1
`define CTL_RX_EN 4
`define CTL_TX_EN 5
`define CTL_RX_IRQ_EN 6
`define CTL_TX_IRQ_EN 7

`define STS_TX_FIFO_EMPTY 5
`define STS_TX_END 6

`define FCR_TX_FIFO_RST 2
`define FCR_TRIG_LO 4
`define FCR_TRIG_HI 5

`define CNT_TX_LO 8

`define FORMAT_RST 8'h00
`define CONTROL_RST 8'h00
`define BIT_RATE_RST 8'hFF
`define FCR_RST 8'h00

`define TRIG_CODE_8 2'h0
`define TRIG_CODE_4 2'h1
`define TRIG_CODE_2 2'h2
`define TRIG_LEVEL_8 5'h08
`define TRIG_LEVEL_4 5'h04
`define TRIG_LEVEL_2 5'h02
`define TRIG_LEVEL_1 5'h01

`define TICKS_PER_BIT 16
`define LAST_TICK 4'hF
`define BITS_LONG 4'h8
`define BITS_SHORT 4'h7

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: tb/serial_peer.sv */
// Remote serial receiver with a free-running external 16x clock
`timescale 1ns/100ps
`default_nettype none
module serial_peer #(
    parameter BIT_CYC = 64
) (
    input wire logic aclk,
    input wire logic line,
    input wire logic [7:0] fmt,
    output logic sck_in,
    output logic [7:0] rx_byte,
    output int rx_cnt,
    output int rx_err
);
    logic [7:0] b;
    // Runs even between frames; a stopped clock would stall the sender
    initial begin
        sck_in = 1'h0;
        #37;
        forever #200 sck_in = ~sck_in;
    end
    initial begin
        rx_cnt = 0;
        rx_err = 0;
        rx_byte = 8'h00;
        forever begin
            @(negedge line);
            repeat (BIT_CYC / 2) @(posedge aclk);
            if (line !== 1'h0) rx_err++;
            b = 8'h00;
            for (int i = 0; i < (fmt[6] ? 7 : 8); i++) begin
                repeat (BIT_CYC) @(posedge aclk);
                b[i] = line;
            end
            if (fmt[5]) begin
                repeat (BIT_CYC) @(posedge aclk);
                if (line !== (^b ^ fmt[4])) rx_err++;
            end
            for (int i = 0; i <= fmt[3]; i++) begin
                repeat (BIT_CYC) @(posedge aclk);
                if (line !== 1'h1) rx_err++;
            end
            rx_byte = b;
            rx_cnt++;
        end
    end
endmodule // serial_peer
`default_nettype wire

/* File: tb/serial_tx_props.sv */
// Port-level assertions for the serial transmitter
`timescale 1ns/100ps
`include "serial_tx_regs.vh"
`default_nettype none
module serial_tx_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [`ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic sck_oe,
    input wire logic txd_out,
    input wire logic txd_oe,
    input wire logic tx_irq
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ctl_wr;
        wr_take ##0 s_axi_awaddr == `OFS_CONTROL;
    endsequence
    a_wr_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `OFS_TX_FIFO
        |=> s_axi_rresp == `RESP_SLVERR) else $error("unmapped read not refused");
    a_clk_out_on: assert property (ctl_wr ##0 s_axi_wdata[1:0] == 2'h1 |-> ##[1:3] sck_oe)
        else $error("clock output not started");
    a_clk_out_off: assert property (ctl_wr ##0 s_axi_wdata[1:0] != 2'h1 |-> ##[1:3] !sck_oe)
        else $error("clock pin driven without output select");
    a_tx_float: assert property (ctl_wr ##0 !s_axi_wdata[5] |-> ##[1:3] !txd_oe)
        else $error("line still driven after disable");
    a_irq_mask: assert property (ctl_wr ##0 !s_axi_wdata[7] |-> ##[1:3] !tx_irq)
        else $error("masked interrupt still raised");
    a_start_low: assert property (txd_oe && $fell(txd_out) |-> (!txd_out)[*8])
        else $error("low bit too short");
endmodule // serial_tx_props
bind serial_tx_top serial_tx_props chk (.*);
`default_nettype wire

/* File: tb/test_async_serial_tx_clock_format.sv */
// Self-checking bench for the serial transmitter
`timescale 1ns/100ps
`include "serial_tx_regs.vh"
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_async_serial_tx_clock_format;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, p;
    logic sck_in, sck_out, sck_oe, txd_out, txd_oe, tx_irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, fmt, rx_byte, e8;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [3:0] s_axi_wstrb;
    int miscompares = 0, comparisons = 0, rx_cnt, rx_err, k, n0;
    time t0;
    wire line;
    assign s_axi_wstrb = 4'hF;
    // Released line idles high through its pull-up
    assign line = (txd_oe === 1'h1) ? txd_out : 1'h1;
    serial_tx_top dut (.*);
    serial_peer peer (.*);
    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, `RESP_OKAY)
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(d, e)
        `CHK(r, `RESP_OKAY)
    endtask
    task automatic wait_rx(input int n);
        while (rx_cnt < n) @(posedge aclk);
    endtask
    task automatic close_out;
        $display("counts: comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        miscompares++;
        close_out;
    end
    initial begin
        aresetn = 1'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fmt} = 56'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rdc(`OFS_STATUS, 32'h60);
        rdc(`OFS_FIFO_CONTROL, 32'h0);
        rdc(`OFS_BIT_RATE, 32'hFF);
        rdc(`OFS_FIFO_COUNT, 32'h0);
        rd(8'h40);
        `CHK(r, `RESP_SLVERR)
        $display("test reset done");
        wr(`OFS_BIT_RATE, 32'h1);
        for (int f = 0; f < 8; f++) begin
            fmt = {1'h0, f[2], f[1], f[0] ^ f[2], f[0], 3'h0};
            wr(`OFS_CONTROL, 32'h0);
            wr(`OFS_FORMAT, {24'h0, fmt});
            repeat (64) @(posedge aclk);
            wr(`OFS_CONTROL, 32'h20);
            wr(`OFS_TX_FIFO, 32'h96 + f);
            wr(`OFS_STATUS, 32'h0);
            `CHK(txd_oe, 1'h1)
            wait_rx(f + 1);
            e8 = 8'h96 + f[7:0];
            `CHK(rx_byte, e8 & {~fmt[6], 7'h7F})
            rdc(`OFS_STATUS, 32'h60);
        end
        `CHK(rx_err, 0)
        $display("test formats done");
        fmt = 8'h0;
        wr(`OFS_CONTROL, 32'h0);
        wr(`OFS_FORMAT, 32'h0);
        wr(`OFS_FIFO_CONTROL, 32'h10);
        for (int i = 0; i < 4; i++) wr(`OFS_TX_FIFO, 32'hC0 + i);
        rdc(`OFS_FIFO_COUNT, 32'h400);
        wr(`OFS_STATUS, 32'h0);
        rdc(`OFS_STATUS, 32'h0);
        wr(`OFS_CONTROL, 32'hA0);
        for (int i = 0; i < 4; i++) begin
            wait_rx(9 + i);
            e8 = 8'hC0 + i[7:0];
            `CHK(rx_byte, e8)
            if (i > 0) `CHK(($time - t0 + 500) / 1000, 64'h40)
            t0 = $time;
        end
        `CHK(tx_irq, 1'h1)
        wr(`OFS_CONTROL, 32'h20);
        @(posedge aclk);
        `CHK(tx_irq, 1'h0)
        $display("test stream done");
        wr(`OFS_CONTROL, 32'h1);
        @(posedge aclk);
        `CHK(sck_oe, 1'h1)
        k = 0;
        p = sck_out;
        repeat (64) begin
            @(posedge aclk);
            k += (sck_out && !p);
            p = sck_out;
        end
        `CHK(k, 16)
        wr(`OFS_CONTROL, 32'h2);
        repeat (64) @(posedge aclk);
        `CHK(sck_oe, 1'h0)
        wr(`OFS_CONTROL, 32'h22);
        wr(`OFS_TX_FIFO, 32'h3C);
        wait_rx(13);
        `CHK(rx_byte, 8'h3C)
        `CHK(rx_err, 0)
        $display("test clock done");
        wr(`OFS_TX_FIFO, 32'h81);
        wr(`OFS_TX_FIFO, 32'h82);
        @(negedge line);
        repeat (90) @(posedge aclk);
        wr(`OFS_CONTROL, 32'h2);
        @(posedge aclk);
        `CHK(txd_oe, 1'h0)
        rdc(`OFS_FIFO_COUNT, 32'h100);
        repeat (800) @(posedge aclk);
        n0 = rx_cnt;
        wr(`OFS_FIFO_CONTROL, 32'h14);
        wr(`OFS_FIFO_CONTROL, 32'h10);
        rdc(`OFS_FIFO_COUNT, 32'h0);
        wr(`OFS_CONTROL, 32'h22);
        repeat (800) @(posedge aclk);
        `CHK(rx_cnt, n0)
        $display("test disable done");
        close_out;
    end
endmodule // test_async_serial_tx_clock_format
`default_nettype wire
